// ==== logic/bcs_pkg.sv ====
// package: constants and carriers for the brake control sequencer
package bcs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_NS         = 1_000_000;   // one millisecond
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_NS;
  localparam int unsigned HOLD_MS         = 100;         // modulation hold after fadeout
  localparam int unsigned IVL_W           = 16;          // interval width in bits, intervals counted in ms
  localparam int unsigned SPD_W           = 16;
  localparam int unsigned NUM_DO          = 8;
  localparam int unsigned NUM_CHK         = 8;
  localparam logic [4:0]  DO_FUNC_BRAKE   = 5'h12;       // output function 18
  localparam logic [3:0]  MODE_OFF        = 4'h0;
  localparam logic [3:0]  MODE_MAX        = 4'h8;
  localparam logic [3:0]  MODE_QS_LO      = 4'h5;
  localparam logic [6:0]  ST_NONE         = 7'h00;
  localparam logic [6:0]  ST_CLOSE        = 7'h55;       // 85
  localparam logic [6:0]  ST_OPEN         = 7'h56;       // 86
  localparam logic [6:0]  ST_STANDSTILL   = 7'h46;       // 70
  localparam logic [6:0]  ERR_BRAKE       = 7'h38;       // 56

  // configured intervals in ms
  typedef struct packed {
    logic [IVL_W-1:0] premag;
    logic [IVL_W-1:0] release_t;
    logic [IVL_W-1:0] delay_t;
    logic [IVL_W-1:0] closing;
    logic [IVL_W-1:0] fadeout;
  } bcs_times_t;

  // supervision inputs from the power stage
  typedef struct packed {
    logic [2:0]       phase_ok;
    logic             hw_cur_limit;
    logic [IVL_W-1:0] load_factor;
  } bcs_meas_t;

  typedef enum {
    BCS_IDLE, BCS_PREMAG, BCS_RELEASE, BCS_RUN, BCS_DELAY,
    BCS_CLOSING, BCS_FADE, BCS_HOLD
  } bcs_state_t;
endpackage

// ==== logic/bcs_ivl_timer.sv ====
// interval down-counter stepped by the millisecond tick
`timescale 1ns/1ps
module bcs_ivl_timer
  import bcs_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [IVL_W-1:0] value_i,
  input  wire logic             tick_i,
  output logic                  done_o
);
  logic [IVL_W-1:0] count;

  // load, then count down once per tick down to zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (tick_i && count != '0) begin
      count <= count - IVL_W'(1);
    end
  end

  // done from the count alone: the load decision depends on done, so done must not
  // depend on the load or the two would form a loop
  assign done_o = (count == '0);
endmodule

// ==== logic/bcs_sequencer.sv ====
// brake control sequencer: timed release and engage of a holding brake
`timescale 1ns/1ps
module bcs_sequencer
  import bcs_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [3:0]               brake_mode_select_i,
  input  wire bcs_times_t               times_i,
  input  wire logic [SPD_W-1:0]         start_speed_reference_i,
  input  wire logic [SPD_W-1:0]         stop_speed_reference_i,
  input  wire logic [SPD_W-1:0]         speed_setpoint_value_i,
  input  wire logic [IVL_W-1:0]         minimum_load_level_i,
  input  wire logic [NUM_DO*5-1:0]      switching_output_select_i,
  input  wire logic [NUM_CHK-1:0]       check_input_select_i,
  input  wire logic [NUM_CHK-1:0]       check_pins_i,
  input  wire logic                     ctrl_release_i,
  input  wire logic                     dir_cmd_i,
  input  wire logic                     drive_fault_i,
  input  wire bcs_meas_t                meas_i,
  output logic [NUM_DO-1:0]             brake_do_o,
  output logic                          modulation_o,
  output logic                          current_fade_o,
  output logic [SPD_W-1:0]              speed_ref_o,
  output logic [6:0]                    status_code_o,
  output logic                          brake_error_o
);
  bcs_state_t state;
  bcs_state_t next_state;
  logic [15:0] tick_cnt;
  logic        tick;
  logic        brake_on;
  logic [NUM_CHK-1:0] chk_s1, chk_s2, chk_s3, chk_q;
  logic        chk_act;
  logic        enabled, display, phase_chk, quick_stop;
  logic        mod_on;
  logic        ivl_load;
  logic [IVL_W-1:0] ivl_val;
  logic        ivl_done;
  logic        closed_zone, open_zone;
  logic        err_phase, err_load, err_cur, err_chk;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // mode decode
  assign enabled    = (brake_mode_select_i != MODE_OFF) &&
                      (brake_mode_select_i <= MODE_MAX);
  assign display    = brake_mode_select_i[0];                      // odd modes show status
  assign phase_chk  = (brake_mode_select_i == 4'h3) || (brake_mode_select_i == 4'h4) ||
                      (brake_mode_select_i == 4'h7) || (brake_mode_select_i == 4'h8);
  assign quick_stop = brake_mode_select_i >= MODE_QS_LO;
  assign mod_on     = ctrl_release_i && !drive_fault_i;

  // millisecond tick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = (tick_cnt == TICK_LAST);

  // check pins: three-stage synchroniser, change accepted when stages 2 and 3 agree
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_s1 <= '0;
      chk_s2 <= '0;
      chk_s3 <= '0;
      chk_q  <= '0;
    end else begin
      chk_s1 <= check_pins_i;
      chk_s2 <= chk_s1;
      chk_s3 <= chk_s2;
      chk_q  <= (chk_s2 & chk_s3) | (chk_q & (chk_s2 | chk_s3));
    end
  end
  assign chk_act = |(chk_q & check_input_select_i);

  // interval timer load value chosen by the state being entered
  always_comb begin
    ivl_load = (next_state != state);
    case (next_state)
      BCS_PREMAG:  ivl_val = times_i.premag;
      BCS_RELEASE: ivl_val = times_i.release_t;
      BCS_DELAY:   ivl_val = times_i.delay_t;
      BCS_CLOSING: ivl_val = times_i.closing;
      BCS_FADE:    ivl_val = times_i.fadeout;
      BCS_HOLD:    ivl_val = IVL_W'(HOLD_MS);
      default:     ivl_val = '0;
    endcase
  end

  bcs_ivl_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (ivl_load),
    .value_i    (ivl_val),
    .tick_i     (tick),
    .done_o     (ivl_done)
  );

  // sequence control
  always_comb begin
    next_state = state;
    if (!enabled) begin
      next_state = BCS_IDLE;
    end else if (!mod_on) begin
      next_state = BCS_IDLE;
    end else begin
      case (state)
        BCS_IDLE:    if (dir_cmd_i) next_state = BCS_PREMAG;
        BCS_PREMAG:  if (ivl_done) next_state = BCS_RELEASE;
        BCS_RELEASE: if (!dir_cmd_i) next_state = BCS_DELAY;
                     else if (ivl_done) next_state = BCS_RUN;
        BCS_RUN:     if (!dir_cmd_i) next_state = BCS_DELAY;
        BCS_DELAY:   if (dir_cmd_i) next_state = BCS_RUN;
                     else if (ivl_done) next_state = BCS_CLOSING;
        BCS_CLOSING: if (dir_cmd_i && quick_stop) next_state = BCS_RELEASE;
                     else if (ivl_done) next_state = BCS_FADE;
        BCS_FADE:    if (ivl_done) next_state = BCS_HOLD;
        BCS_HOLD:    if (ivl_done) next_state = BCS_IDLE;
        default:     next_state = BCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // brake release level, dropped combinationally when modulation stops
  assign brake_on = mod_on && enabled &&
                    (state == BCS_RELEASE || state == BCS_RUN || state == BCS_DELAY);

  // brake output per switching output with function 18
  genvar g;
  generate
    for (g = 0; g < NUM_DO; g++) begin : g_do
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          brake_do_o[g] <= 1'b0;
        end else begin
          brake_do_o[g] <= (next_state == BCS_RELEASE || next_state == BCS_RUN ||
                            next_state == BCS_DELAY) &&
                           (switching_output_select_i[g*5 +: 5] == DO_FUNC_BRAKE);
        end
      end
      // a brake-selected output follows the release step
      do_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        next_state == BCS_RELEASE && switching_output_select_i[g*5 +: 5] == DO_FUNC_BRAKE
          |=> brake_do_o[g])
        else $error("brake output missing at release");
    end
  endgenerate

  // drive command outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      modulation_o   <= 1'b0;
      current_fade_o <= 1'b0;
      speed_ref_o    <= '0;
    end else begin
      modulation_o   <= (next_state != BCS_IDLE);
      current_fade_o <= (next_state == BCS_FADE) || (next_state == BCS_HOLD);
      case (next_state)
        BCS_PREMAG, BCS_RELEASE: speed_ref_o <= start_speed_reference_i;
        BCS_RUN:                 speed_ref_o <= speed_setpoint_value_i;
        BCS_DELAY, BCS_CLOSING,
        BCS_FADE, BCS_HOLD:      speed_ref_o <= stop_speed_reference_i;
        default:                 speed_ref_o <= '0;
      endcase
    end
  end

  // supervision windows
  assign closed_zone = (state == BCS_IDLE && !mod_on) || state == BCS_FADE ||
                       state == BCS_HOLD || state == BCS_PREMAG ||
                       (state == BCS_IDLE && modulation_o == 1'b0);
  assign open_zone   = state == BCS_RUN || state == BCS_DELAY;
  assign err_phase   = phase_chk && (state != BCS_IDLE) && (meas_i.phase_ok != 3'b111);
  assign err_load    = state == BCS_PREMAG && ivl_done && (minimum_load_level_i != '0) &&
                       (meas_i.load_factor < minimum_load_level_i);
  assign err_cur     = state == BCS_PREMAG && ivl_done && meas_i.hw_cur_limit;
  assign err_chk     = (check_input_select_i != '0) &&
                       ((closed_zone && chk_act) || (open_zone && !chk_act));

  // sticky brake error, cleared when the function is disabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brake_error_o <= 1'b0;
    end else if (enabled && (err_phase || err_load || err_cur || err_chk)) begin
      brake_error_o <= 1'b1;
    end else if (!enabled) begin
      brake_error_o <= 1'b0;
    end
  end

  // status code
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_code_o <= ST_STANDSTILL;
    end else if (enabled && (err_phase || err_load || err_cur || err_chk || brake_error_o)) begin
      status_code_o <= ERR_BRAKE;
    end else if (next_state == BCS_IDLE) begin
      status_code_o <= ST_STANDSTILL;
    end else if (enabled && display && (next_state == BCS_PREMAG || next_state == BCS_RELEASE)) begin
      status_code_o <= ST_OPEN;
    end else if (enabled && display && next_state != BCS_RUN) begin
      status_code_o <= ST_CLOSE;
    end else begin
      status_code_o <= ST_NONE;
    end
  end

  // assertions
  sequence s_delay_done;
    state == BCS_DELAY && next_state == BCS_CLOSING;
  endsequence

  brake_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_delay_done |=> brake_do_o == '0)
    else $error("brake output still on after delay interval");
  mode_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    brake_mode_select_i == MODE_OFF |=> state == BCS_IDLE)
    else $error("sequencer active in mode zero");
  mod_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !mod_on |-> !brake_on ##1 brake_do_o == '0)
    else $error("brake held after modulation off");
  release_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == BCS_RELEASE && $stable(state) |-> speed_ref_o == start_speed_reference_i)
    else $error("release interval not on start reference");
  quick_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == BCS_CLOSING && dir_cmd_i && quick_stop && mod_on && enabled |=> state == BCS_RELEASE)
    else $error("quick stop restart missed");
  load_err_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && err_load |=> brake_error_o && status_code_o == ERR_BRAKE)
    else $error("minimum load error not raised");
  fade_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == BCS_FADE && next_state == BCS_HOLD |=> modulation_o [*8])
    else $error("modulation dropped right after fadeout");
  open_status_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && !display && !brake_error_o && (state == BCS_PREMAG || state == BCS_RELEASE)
      && $stable(state) && $stable(brake_mode_select_i)
      && !err_phase && !err_chk |-> status_code_o == ST_NONE)
    else $error("status shown in a mode without display");

  sequence s_close_done;
    state == BCS_CLOSING && next_state == BCS_FADE;
  endsequence
  sequence s_hold_done;
    state == BCS_HOLD && next_state == BCS_IDLE;
  endsequence

  brake_state_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    brake_do_o != '0 |-> state == BCS_RELEASE || state == BCS_RUN || state == BCS_DELAY)
    else $error("brake output on outside the open phases");
  idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == BCS_IDLE && !mod_on |=> state == BCS_IDLE)
    else $error("sequence started without control release");
  phase_err_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && phase_chk && state != BCS_IDLE && meas_i.phase_ok != 3'b111 |=> brake_error_o)
    else $error("missing phase not flagged");
  cur_err_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && state == BCS_PREMAG && ivl_done && meas_i.hw_cur_limit |=> brake_error_o)
    else $error("current limit before opening not flagged");
  sup_window_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && !brake_error_o && state != BCS_PREMAG && !err_phase && !err_chk |=> !brake_error_o)
    else $error("load or current supervised outside the opening moment");
  closed_chk_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && check_input_select_i != '0 && (state == BCS_IDLE || state == BCS_PREMAG)
      && chk_act |=> brake_error_o)
    else $error("check contact made while brake closed not flagged");
  open_chk_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && check_input_select_i != '0 && (state == BCS_RUN || state == BCS_DELAY)
      && !chk_act |=> brake_error_o)
    else $error("check contact open while brake released not flagged");
  close_status_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    enabled && display && state == BCS_CLOSING && $stable(state)
      && $stable(brake_mode_select_i) && !brake_error_o |-> status_code_o == ST_CLOSE)
    else $error("closing status not shown");
  fade_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_close_done |=> current_fade_o && modulation_o)
    else $error("fadeout not started after closing");
  standstill_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_hold_done |=> !modulation_o && !current_fade_o
      && (brake_error_o || status_code_o == ST_STANDSTILL))
    else $error("standstill not reached after hold");
endmodule

// ==== tb/bcs_brake_model.sv ====
// brake actuator model: the coil follows the brake outputs, the check contact lags it
`timescale 1ns/1ps
module bcs_brake_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       brake_on_i,
  input  wire logic [1:0] fault_i,
  input  wire logic [7:0] lag_i,
  output logic            fb_o
);
  logic [7:0] cnt;
  // contact moves lag_i+1 cycles after the coil; fault 1 holds it open, fault 2 holds it made
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt  <= 8'h00;
      fb_o <= 1'b0;
    end else begin
      cnt <= (fb_o == brake_on_i) ? 8'h00 : cnt + 8'h01;
      if (fault_i == 2'h1) fb_o <= 1'b0;
      else if (fault_i == 2'h2) fb_o <= 1'b1;
      else if (fb_o != brake_on_i && cnt >= lag_i) fb_o <= brake_on_i;
    end
  end
endmodule

// ==== tb/bcs_sequencer_tb.sv ====
// testbench for the brake control sequencer
`timescale 1ns/1ps
module bcs_sequencer_tb
  import bcs_pkg::*;
;
  // error cases: mode, phases ok, load case, current limit, error expected
  localparam logic [3:0] E_MODE [7] = '{4'h3, 4'h2, 4'h1, 4'h1, 4'h1, 4'h4, 4'h1};
  localparam logic [2:0] E_PH   [7] = '{3'h6, 3'h6, 3'h7, 3'h7, 3'h7, 3'h3, 3'h7};
  localparam logic [1:0] E_LD   [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2};
  localparam logic       E_CUR  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic       E_ERR  [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic                clk, rst_n, ctrl, dir, fb, mod_on, fade, err, fault;
  logic [3:0]          mode;
  logic [1:0]          fb_fault;
  logic [7:0]          lag;
  bcs_times_t          tm;
  bcs_meas_t           meas;
  logic [SPD_W-1:0]    v_start, v_stop, v_set, spd;
  logic [IVL_W-1:0]    min_load;
  logic [NUM_DO*5-1:0] do_sel;
  logic [NUM_DO-1:0]   brake_do, exp_do;
  logic [NUM_CHK-1:0]  chk_sel, ck, pins_rnd, pins;
  logic [6:0]          status;
  int                  n_fail, tests_run, k;

`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 30000) begin cyc(1); k++; end \
  if (k >= 30000) begin n_fail++; print_verdict(); end end

  // outputs whose function select names the brake
  function automatic logic [NUM_DO-1:0] brake_mask(input logic [NUM_DO*5-1:0] s);
    for (int g = 0; g < NUM_DO; g++) brake_mask[g] = (s[g*5+:5] == DO_FUNC_BRAKE);
  endfunction
  // brake status shows only in the display modes (odd values)
  function automatic logic [6:0] disp(input logic [3:0] m, input logic [6:0] c);
    return m[0] ? c : ST_NONE;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d, wrong %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // only the selected check pin carries the contact; the others hold noise
  assign pins = (pins_rnd & ~chk_sel) | (fb ? chk_sel : '0);

  bcs_sequencer dut_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .brake_mode_select_i(mode), .times_i(tm),
    .start_speed_reference_i(v_start), .stop_speed_reference_i(v_stop),
    .speed_setpoint_value_i(v_set), .minimum_load_level_i(min_load),
    .switching_output_select_i(do_sel), .check_input_select_i(chk_sel),
    .check_pins_i(pins), .ctrl_release_i(ctrl), .dir_cmd_i(dir), .drive_fault_i(fault),
    .meas_i(meas), .brake_do_o(brake_do), .modulation_o(mod_on), .current_fade_o(fade),
    .speed_ref_o(spd), .status_code_o(status), .brake_error_o(err));
  bcs_brake_model brake_u (.core_clk_i(clk), .rst_n_i(rst_n), .brake_on_i(|brake_do),
    .fault_i(fb_fault), .lag_i(lag), .fb_o(fb));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    void'($urandom(59136));
    rst_n = 1'b0; ctrl = 1'b0; dir = 1'b0; mode = 4'h0; fb_fault = 2'h0;
    fault = 1'b0;
    lag = 8'($urandom % 20); min_load = '0; v_set = '0; pins_rnd = 8'($urandom);
    v_start = 16'($urandom) | 16'h0001; v_stop = 16'($urandom) | 16'h0002;
    meas = '{phase_ok: 3'h7, hw_cur_limit: 1'b0, load_factor: 16'h0000};
    tm = '{premag: 16'h0000, release_t: 16'h0001, delay_t: 16'h0000,
           closing: 16'h0001, fadeout: 16'h0000};
    for (int g = 0; g < NUM_DO; g++) do_sel[g*5+:5] = ($urandom % 2) ? 5'h12 : 5'($urandom % 18);
    do_sel[5*($urandom % NUM_DO)+:5] = DO_FUNC_BRAKE;
    exp_do = brake_mask(do_sel);
    ck = 8'h01 << ($urandom % NUM_CHK);
    chk_sel = ck;
    cyc(16);
    `CHK("status in reset", ST_STANDSTILL, status)
    `CHK("brake in reset", 8'h00, brake_do)
    rst_n = 1'b1;
    // disabled mode ignores a start
    ctrl = 1'b1; dir = 1'b1; cyc(30);
    `CHK("modulation mode 0", 1'b0, mod_on)
    `CHK("brake mode 0", 8'h00, brake_do)
    dir = 1'b0; mode = 4'(1 + $urandom % 8); cyc(3);
    $display("test disable done");
    // full open and close sequence at setpoint zero
    dir = 1'b1;
    `WAITC(brake_do != 0)
    `CHK("brake outputs", exp_do, brake_do)
    `CHK("open status", disp(mode, ST_OPEN), status)
    cyc(5000);
    `CHK("speed in release", v_start, spd)
    `WAITC(spd === v_set)
    meas.hw_cur_limit = 1'b1; cyc(20); meas.hw_cur_limit = 1'b0;
    `CHK("error in run", 1'b0, err)
    dir = 1'b0;
    `WAITC(spd === v_stop)
    `CHK("close status", disp(mode, ST_CLOSE), status)
    `WAITC(brake_do == 0)
    cyc(5000);
    `CHK("speed in closing", v_stop, spd)
    `WAITC(fade === 1'b1)
    cyc(2000);
    `CHK("modulation in hold", 1'b1, mod_on)
    `CHK("fade in hold", 1'b1, fade)
    `CHK("error closed", 1'b0, err)
    ctrl = 1'b0; cyc(3);
    `CHK("modulation off", 1'b0, mod_on)
    `CHK("standstill", ST_STANDSTILL, status)
    $display("test sequence done");
    // restart during closing: quick-stop mode 5 reopens, mode 1 without quick stop does not
    chk_sel = '0; tm.release_t = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      mode = i ? 4'h1 : 4'h5; ctrl = 1'b1; dir = 1'b1;
      `WAITC(brake_do != 0)
      cyc(3); dir = 1'b0;
      `WAITC(brake_do == 0)
      cyc(100); dir = 1'b1; cyc(20);
      `CHK("restart in closing", i ? 8'h00 : exp_do, brake_do)
      ctrl = 1'b0; cyc(2);
      `CHK("brake at modulation off", 8'h00, brake_do)
      dir = 1'b0; cyc(3);
    end
    $display("test quick stop done");
    // phase, load and current supervision
    for (int i = 0; i < 7; i++) begin
      mode = 4'h0; cyc(3);
      mode = E_MODE[i]; meas.phase_ok = E_PH[i]; meas.hw_cur_limit = E_CUR[i];
      min_load = (E_LD[i] == 0) ? 16'h0000 : 16'($urandom % 1000 + 2);
      meas.load_factor = (E_LD[i] == 1) ? min_load - 16'h0001 : min_load;
      ctrl = 1'b1; dir = 1'b1;
      `WAITC(err || brake_do != 0)
      cyc(6);
      `CHK("supervision error", E_ERR[i], err)
      if (E_ERR[i]) `CHK("error status", ERR_BRAKE, status)
      meas = '{phase_ok: 3'h7, hw_cur_limit: 1'b0, load_factor: 16'h0000};
      ctrl = 1'b0; dir = 1'b0; cyc(3);
    end
    $display("test supervision done");
    // brake check contact stuck made while closed, then stuck open after release
    mode = 4'h0; chk_sel = ck; min_load = '0; tm.release_t = 16'h0001; cyc(3);
    mode = 4'h1; fb_fault = 2'h2; cyc(20);
    `CHK("contact made at rest", 1'b1, err)
    fb_fault = 2'h0; cyc(40); mode = 4'h0; cyc(3);
    mode = 4'h2; fb_fault = 2'h1; ctrl = 1'b1; dir = 1'b1;
    `WAITC(brake_do != 0)
    cyc(100);
    `CHK("contact during release", 1'b0, err)
    `CHK("status without display", ST_NONE, status)
    `WAITC(err === 1'b1)
    `CHK("contact open in run", 1'b1, err)
    fault = 1'b1;
    cyc(2);
    `CHK("brake at drive fault", 8'h00, brake_do)
    `CHK("modulation at drive fault", 1'b0, mod_on)
    $display("test check input done");
    print_verdict();
  end
endmodule
